/* File: rtl/stswc_cmd.sv */
`timescale 1ns/10ps
`include "stswc_regs.svh"
module stswc_cmd #(
    parameter int BIT_CYC = `STSWC_CLK_HZ / `STSWC_BAUD_BPS,
    parameter logic [2:0] CHIP_REV = 3'h0 // Arbitrary revision value
) (
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    // Host serial lines
    input wire logic TXD_I,
    output logic RXD_O,
    // Bus engine requests
    output logic BUS_REQ_O,
    output stswc_pkg::stswc_bus_op_t BUS_OP_O,
    output logic [7:0] BUS_WDATA_O,
    input wire logic BUS_DONE_I,
    input wire logic [7:0] BUS_RDATA_I,
    input wire logic PRESENCE_EVT_I,
    // Strong pullup and programming pulse
    output logic SPU_REQ_O,
    output logic SPU_PROG_O,
    output logic SPU_STOP_O,
    input wire logic SPU_DONE_I,
    // Configuration parameters
    output logic CFG_WR_O,
    output logic [2:0] CFG_PARAM_O,
    output logic [2:0] CFG_VALUE_O,
    input wire logic [2:0] CFG_RDATA_I,
    // Status
    output stswc_pkg::stswc_speed_t SPEED_O,
    output logic SEARCH_EN_O,
    output logic SPU_ARM_O,
    output logic DATA_MODE_O,
    output logic CAL_PENDING_O
);
    typedef enum {ST_IDLE, ST_BUS, ST_RESP1, ST_PULSE, ST_RESP2} stswc_st_t;
    stswc_st_t st_ff;
    logic srst;
    logic mreset_ff;
    logic rx_vld;
    logic [7:0] rx_byte;
    logic rx_brk;
    logic tx_busy;
    logic tx_start;
    logic [7:0] tx_byte;
    logic check_ff;
    logic [7:0] cur_ff;
    logic is_data_ff;
    logic pulse_after_ff;
    logic [7:0] resp1_ff;
    logic [7:0] resp2_ff;
    logic pres_ff;
    logic [7:0] exec_byte;
    logic exec_cmd;
    logic exec_data;

    // ================================================================
    // Speed decode shared by three command kinds
    function automatic stswc_pkg::stswc_speed_t speed_of(input logic [7:0] c);
        unique case (c[3:2])
            2'b01: speed_of = stswc_pkg::SPEED_FLEX;
            2'b10: speed_of = stswc_pkg::SPEED_OVERDRIVE;
            default: speed_of = stswc_pkg::SPEED_REGULAR;
        endcase
    endfunction

    // ================================================================
    // Serial port
    // character framing
    stswc_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
        .clk_i(REF_CLK_I),
        .srst_i(srst),
        .rx_i(TXD_I),
        .byte_vld_o(rx_vld),
        .byte_o(rx_byte),
        .brk_o(rx_brk)
    );

    stswc_uart_tx #(.BIT_CYC(BIT_CYC)) u_tx (
        .clk_i(REF_CLK_I),
        .srst_i(srst),
        .start_i(tx_start),
        .byte_i(tx_byte),
        .busy_o(tx_busy),
        .tx_o(RXD_O)
    );

    // ================================================================
    // Master reset
    // break resets all
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
            mreset_ff <= 1'b0;
        else
            mreset_ff <= rx_brk;
    end

    assign srst = !RST_N_I || mreset_ff;

    // ================================================================
    // Byte routing; bytes arriving while busy are dropped except F1 during a command-mode pulse
    always_comb
    begin
        exec_byte = rx_byte;
        exec_cmd = 1'b0;
        exec_data = 1'b0;
        if (rx_vld && st_ff == ST_IDLE && !CAL_PENDING_O)
        begin
            if (check_ff)
            begin
                if (rx_byte == `STSWC_CODE_CMD)
                    exec_data = 1'b1;
                else
                    exec_cmd = 1'b1;
            end
            else if (DATA_MODE_O)
            begin
                exec_data = (rx_byte != `STSWC_CODE_CMD);
            end
            else
            begin
                exec_cmd = 1'b1;
            end
        end
    end

    // ================================================================
    // Calibration byte
    // consumed silently
    always_ff @(posedge REF_CLK_I)
    begin
        if (srst)
            CAL_PENDING_O <= 1'b1;
        else if (rx_vld)
            CAL_PENDING_O <= 1'b0;
    end

    // ================================================================
    // Mode flags
    always_ff @(posedge REF_CLK_I)
    begin
        if (srst)
        begin
            DATA_MODE_O <= 1'b0;
            check_ff <= 1'b0;
        end
        else if (rx_vld && st_ff == ST_IDLE && !CAL_PENDING_O)
        begin
            if (check_ff)
            begin
                check_ff <= 1'b0;
                DATA_MODE_O <= (rx_byte == `STSWC_CODE_CMD);
            end
            else if (DATA_MODE_O && rx_byte == `STSWC_CODE_CMD)
                check_ff <= 1'b1;
            else if (!DATA_MODE_O && rx_byte == `STSWC_CODE_DATA)
                DATA_MODE_O <= 1'b1;
        end
    end

    // ================================================================
    // Latched configuration flags
    always_ff @(posedge REF_CLK_I)
    begin
        if (srst)
        begin
            SPEED_O <= stswc_pkg::SPEED_REGULAR;
            SEARCH_EN_O <= 1'b0;
            SPU_ARM_O <= 1'b0;
            SPU_PROG_O <= 1'b0;
        end
        else if (exec_cmd && exec_byte[`STSWC_CMD_SEL_BIT])
        begin
            if (exec_byte[6:5] != 2'b11 && (exec_byte[6:5] == 2'b00 || !exec_byte[1]))
                SPEED_O <= speed_of(exec_byte);
            if (exec_byte[6:5] == 2'b01 && !exec_byte[1])
                SEARCH_EN_O <= exec_byte[`STSWC_TYPE_BIT];
            if (exec_byte[6:5] == 2'b11 && exec_byte[3:2] == 2'b11
                && exec_byte != `STSWC_CODE_TERM)
            begin
                SPU_ARM_O <= exec_byte[`STSWC_SPU_BIT];
                SPU_PROG_O <= exec_byte[`STSWC_TYPE_BIT];
            end
        end
        else if (exec_data)
            SPU_PROG_O <= 1'b0;
    end

    // ================================================================
    // Configuration access
    // read or write
    always_comb
    begin
        CFG_WR_O = exec_cmd && !exec_byte[`STSWC_CMD_SEL_BIT]
            && exec_byte[6:4] != `STSWC_CFG_READ;
        CFG_PARAM_O = exec_byte[6:4];
        CFG_VALUE_O = exec_byte[3:1];
    end

    // ================================================================
    // Command and data sequencer
    always_ff @(posedge REF_CLK_I)
    begin
        BUS_REQ_O <= 1'b0;
        SPU_REQ_O <= 1'b0;
        SPU_STOP_O <= 1'b0;
        if (srst)
        begin
            st_ff <= ST_IDLE;
            cur_ff <= 8'h00;
            is_data_ff <= 1'b0;
            pulse_after_ff <= 1'b0;
            resp1_ff <= 8'h00;
            resp2_ff <= 8'h00;
            BUS_OP_O <= stswc_pkg::BUS_OP_RESET;
            BUS_WDATA_O <= 8'h00;
        end
        else
        begin
            unique case (st_ff)
                ST_IDLE:
                    if (exec_data)
                    begin
                        BUS_REQ_O <= 1'b1;
                        BUS_OP_O <= SEARCH_EN_O ? stswc_pkg::BUS_OP_SEARCH
                            : stswc_pkg::BUS_OP_BYTE;
                        BUS_WDATA_O <= exec_byte;
                        cur_ff <= exec_byte;
                        is_data_ff <= 1'b1;
                        pulse_after_ff <= SPU_ARM_O;
                        st_ff <= ST_BUS;
                    end
                    else if (exec_cmd)
                    begin
                        cur_ff <= exec_byte;
                        is_data_ff <= 1'b0;
                        if (!exec_byte[`STSWC_CMD_SEL_BIT])
                        begin
                            resp1_ff <= exec_byte[6:4] == `STSWC_CFG_READ
                                ? {1'b0, exec_byte[3:1], CFG_RDATA_I, 1'b0}
                                : {exec_byte[7:1], 1'b0};
                            pulse_after_ff <= 1'b0;
                            st_ff <= ST_RESP1;
                        end
                        else if (exec_byte[6:5] == 2'b00 && exec_byte[0])
                        begin
                            BUS_REQ_O <= 1'b1;
                            BUS_OP_O <= stswc_pkg::BUS_OP_BIT;
                            BUS_WDATA_O <= {7'h00, exec_byte[`STSWC_TYPE_BIT]};
                            pulse_after_ff <= exec_byte[`STSWC_SPU_BIT];
                            st_ff <= ST_BUS;
                        end
                        else if (exec_byte[6:5] == 2'b10 && exec_byte[1:0] == 2'b01)
                        begin
                            BUS_REQ_O <= 1'b1;
                            BUS_OP_O <= stswc_pkg::BUS_OP_RESET;
                            pulse_after_ff <= 1'b0;
                            st_ff <= ST_BUS;
                        end
                        else if (exec_byte[6:5] == 2'b11 && exec_byte[3:2] == 2'b11
                            && exec_byte[0])
                        begin
                            SPU_REQ_O <= 1'b1;
                            st_ff <= ST_PULSE;
                        end
                    end
                ST_BUS:
                    if (BUS_DONE_I)
                    begin
                        if (is_data_ff)
                            resp1_ff <= BUS_RDATA_I;
                        else if (cur_ff[6:5] == 2'b00)
                            resp1_ff <= {cur_ff[7:2], {2{BUS_RDATA_I[0]}}};
                        else
                            resp1_ff <= {`STSWC_RESET_PREFIX, CHIP_REV[2], 1'b0,
                                CHIP_REV[0], BUS_RDATA_I[1:0]};
                        st_ff <= ST_RESP1;
                    end
                ST_RESP1:
                    if (!tx_busy)
                    begin
                        if (pulse_after_ff)
                        begin
                            SPU_REQ_O <= 1'b1;
                            st_ff <= ST_PULSE;
                        end
                        else
                            st_ff <= ST_IDLE;
                    end
                ST_PULSE:
                    if (rx_vld && rx_byte == `STSWC_CODE_TERM && !DATA_MODE_O)
                    begin
                        SPU_STOP_O <= 1'b1;
                        resp2_ff <= {cur_ff[7:2], 2'b00};
                        st_ff <= ST_RESP2;
                    end
                    else if (SPU_DONE_I)
                    begin
                        if (!is_data_ff && cur_ff[6:5] == 2'b00)
                            resp2_ff <= resp1_ff[0] ? `STSWC_RESP_BIT_ONE
                                : `STSWC_RESP_BIT_ZERO;
                        else if (is_data_ff)
                            resp2_ff <= cur_ff[7] ? `STSWC_RESP_SPU_HI
                                : `STSWC_RESP_SPU_LO;
                        else
                            resp2_ff <= {cur_ff[7:2], 2'b00};
                        st_ff <= ST_RESP2;
                    end
                ST_RESP2:
                    if (!tx_busy)
                        st_ff <= ST_IDLE;
            endcase
        end
    end

    // ================================================================
    // Unsolicited presence; an event during a clear is kept
    // command mode only
    always_ff @(posedge REF_CLK_I)
    begin
        if (srst)
            pres_ff <= 1'b0;
        else if (PRESENCE_EVT_I && !DATA_MODE_O && !check_ff && st_ff == ST_IDLE)
            pres_ff <= 1'b1;
        else if (tx_start && tx_byte == `STSWC_RESP_PRESENCE && st_ff == ST_IDLE)
            pres_ff <= 1'b0;
    end

    // ================================================================
    // Answer byte selection
    always_comb
    begin
        tx_start = 1'b0;
        tx_byte = resp1_ff;
        if (!tx_busy)
        begin
            if (st_ff == ST_RESP1)
                tx_start = 1'b1;
            else if (st_ff == ST_RESP2)
            begin
                tx_start = 1'b1;
                tx_byte = resp2_ff;
            end
            else if (st_ff == ST_IDLE && pres_ff)
            begin
                tx_start = 1'b1;
                tx_byte = `STSWC_RESP_PRESENCE;
            end
        end
    end
endmodule

/* File: rtl/stswc_pkg.sv */
package stswc_pkg;
    typedef enum logic [1:0]
    {
        BUS_OP_RESET,
        BUS_OP_BIT,
        BUS_OP_BYTE,
        BUS_OP_SEARCH
    } stswc_bus_op_t;
    typedef enum logic [1:0]
    {
        SPEED_REGULAR,
        SPEED_FLEX,
        SPEED_OVERDRIVE
    } stswc_speed_t;
endpackage

/* File: rtl/stswc_regs.svh */
`ifndef STSWC_REGS_SVH
`define STSWC_REGS_SVH
// ====================================================================
// Clock and serial timing
`define STSWC_CLK_HZ 100000000
`define STSWC_BAUD_BPS 9600
// ====================================================================
// Reserved codes
`define STSWC_CODE_DATA 8'hE1
`define STSWC_CODE_CMD 8'hE3
`define STSWC_CODE_TERM 8'hF1
// ====================================================================
// Command field positions
`define STSWC_CMD_SEL_BIT 7
`define STSWC_TYPE_BIT 4
`define STSWC_SPU_BIT 1
// ====================================================================
// Response codes and configuration read parameter code
`define STSWC_RESP_BIT_ONE 8'hEF
`define STSWC_RESP_BIT_ZERO 8'hEC
`define STSWC_RESP_SPU_HI 8'hF6
`define STSWC_RESP_SPU_LO 8'h76
`define STSWC_RESP_PRESENCE 8'h01
`define STSWC_RESET_PREFIX 3'h6
`define STSWC_CFG_READ 3'h0
`endif

/* File: rtl/stswc_uart_rx.sv */
`timescale 1ns/10ps
module stswc_uart_rx #(
    parameter int BIT_CYC = 10416
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Serial line
    input wire logic rx_i,
    // Received character
    output logic byte_vld_o,
    output logic [7:0] byte_o,
    output logic brk_o
);
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_WAIT_HI} stswc_rx_st_t;
    stswc_rx_st_t st_ff;
    logic sync1_ff;
    logic sync2_ff;
    logic [15:0] cnt_ff;
    logic [2:0] bit_ff;
    logic [7:0] sh_ff;
    localparam logic [15:0] FULL = 16'(BIT_CYC - 1);
    localparam logic [15:0] HALF = 16'(BIT_CYC / 2 - 1);

    // ================================================================
    // Pin synchroniser
    always_ff @(posedge clk_i)
    begin
        sync1_ff <= rx_i;
        sync2_ff <= sync1_ff;
    end

    // ================================================================
    // Framing; two stop bits pass because the line just idles high
    always_ff @(posedge clk_i)
    begin
        byte_vld_o <= 1'b0;
        brk_o <= 1'b0;
        if (srst_i)
        begin
            st_ff <= RX_IDLE;
            cnt_ff <= 16'h0000;
            bit_ff <= 3'h0;
            sh_ff <= 8'h00;
            byte_o <= 8'h00;
        end
        else
        begin
            if (cnt_ff != 16'h0000)
                cnt_ff <= cnt_ff - 16'h0001;
            unique case (st_ff)
                RX_IDLE:
                    if (!sync2_ff)
                    begin
                        st_ff <= RX_START;
                        cnt_ff <= HALF;
                    end
                RX_START:
                    if (cnt_ff == 16'h0000)
                    begin
                        st_ff <= sync2_ff ? RX_IDLE : RX_DATA;
                        cnt_ff <= FULL;
                        bit_ff <= 3'h0;
                    end
                RX_DATA:
                    if (cnt_ff == 16'h0000)
                    begin
                        sh_ff <= {sync2_ff, sh_ff[7:1]};
                        cnt_ff <= FULL;
                        bit_ff <= bit_ff + 3'h1;
                        if (bit_ff == 3'h7)
                            st_ff <= RX_STOP;
                    end
                RX_STOP:
                    if (cnt_ff == 16'h0000)
                    begin
                        // Start level where the stop bit belongs is a break
                        if (sync2_ff)
                        begin
                            byte_o <= sh_ff;
                            byte_vld_o <= 1'b1;
                            st_ff <= RX_IDLE;
                        end
                        else
                        begin
                            brk_o <= 1'b1;
                            st_ff <= RX_WAIT_HI;
                        end
                    end
                RX_WAIT_HI:
                    if (sync2_ff)
                        st_ff <= RX_IDLE;
            endcase
        end
    end
endmodule

/* File: rtl/stswc_uart_tx.sv */
`timescale 1ns/10ps
module stswc_uart_tx #(
    parameter int BIT_CYC = 10416
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Byte to send
    input wire logic start_i,
    input wire logic [7:0] byte_i,
    output logic busy_o,
    // Serial line
    output logic tx_o
);
    logic [9:0] sh_ff;
    logic [3:0] left_ff;
    logic [15:0] cnt_ff;
    localparam logic [15:0] FULL = 16'(BIT_CYC - 1);

    // Busy covers the whole stop bit so that a following byte cannot cut it short
    assign busy_o = (left_ff != 4'h0) || (cnt_ff != 16'h0000);

    // ================================================================
    // One start, eight data, one stop bit, LSB first
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            sh_ff <= 10'h3FF;
            left_ff <= 4'h0;
            cnt_ff <= 16'h0000;
            tx_o <= 1'b1;
        end
        else if (left_ff == 4'h0 && cnt_ff == 16'h0000)
        begin
            if (start_i)
            begin
                sh_ff <= {1'b1, byte_i, 1'b0};
                left_ff <= 4'hA;
                cnt_ff <= 16'h0000;
            end
        end
        else if (cnt_ff == 16'h0000)
        begin
            tx_o <= sh_ff[0];
            sh_ff <= {1'b1, sh_ff[9:1]};
            left_ff <= left_ff - 4'h1;
            cnt_ff <= FULL;
        end
        else
        begin
            cnt_ff <= cnt_ff - 16'h0001;
        end
    end
endmodule

/* File: verification/stswc_host.sv */
`timescale 1ns/10ps
// ====================================================================
// Host serial port
module stswc_host #(
    parameter int BIT_CYC = 16
) (
    // Clock
    input wire logic clk_i,
    // Serial lines
    input wire logic rxd_i,
    output logic txd_o
);
    initial txd_o = 1'b1;
    task automatic send(input logic [7:0] b, input bit brk);
        logic [9:0] f;
        f = {!brk, b, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            txd_o <= i < 10 ? f[i] : 1'b1;
            repeat (BIT_CYC) @(negedge clk_i);
        end
    endtask
    // one stop bit, a missing answer stays unknown
    task automatic recv(output logic [7:0] b);
        int n;
        n = 0;
        b = 8'hXX;
        while (rxd_i !== 1'b0 && n < 1500)
        begin
            @(negedge clk_i);
            n++;
        end
        if (n < 1500)
        begin
            repeat (BIT_CYC / 2) @(negedge clk_i);
            for (int i = 0; i < 8; i++)
            begin
                repeat (BIT_CYC) @(negedge clk_i);
                b[i] = rxd_i;
            end
            repeat (BIT_CYC) @(negedge clk_i);
            if (rxd_i !== 1'b1)
                b = 8'hXX;
        end
    endtask
endmodule

/* File: verification/stswc_props.sv */
`timescale 1ns/10ps
// ====================================================================
// Port checker
module stswc_props (
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    // Watched outputs
    input wire logic RXD_O,
    input wire logic BUS_REQ_O,
    input wire stswc_pkg::stswc_bus_op_t BUS_OP_O,
    input wire logic SPU_REQ_O,
    input wire logic SPU_STOP_O,
    input wire logic CFG_WR_O,
    input wire logic [2:0] CFG_PARAM_O,
    input wire stswc_pkg::stswc_speed_t SPEED_O,
    input wire logic SEARCH_EN_O,
    input wire logic SPU_ARM_O,
    input wire logic DATA_MODE_O,
    input wire logic CAL_PENDING_O
);
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    // One operation at a time: the engine needs several cycles anyway
    sequence s_quiet;
        !BUS_REQ_O [*4];
    endsequence
    a_rst_clean:
    assert property ($rose(RST_N_I) |-> CAL_PENDING_O && !DATA_MODE_O && RXD_O
        && !SEARCH_EN_O && !SPU_ARM_O && SPEED_O == 2'h0) else $error("bad reset state");
    a_cal_no_bus:
    assert property (CAL_PENDING_O |-> !BUS_REQ_O && !SPU_REQ_O) else $error("bus during cal");
    a_req_quiet:
    assert property (BUS_REQ_O |=> s_quiet) else $error("request too soon");
    a_op_search:
    assert property (BUS_REQ_O && BUS_OP_O inside {stswc_pkg::BUS_OP_BYTE,
        stswc_pkg::BUS_OP_SEARCH} |-> (BUS_OP_O == stswc_pkg::BUS_OP_SEARCH) == SEARCH_EN_O)
        else $error("wrong byte op");
    a_spu_armed:
    assert property (SPU_REQ_O && DATA_MODE_O |-> SPU_ARM_O) else $error("unarmed pullup");
    a_term_cmd:
    assert property (SPU_STOP_O |-> !DATA_MODE_O) else $error("stop in data mode");
    a_speed_code:
    assert property (SPEED_O != 2'h3) else $error("illegal speed");
    a_cfg_wr_code:
    assert property (CFG_WR_O |-> CFG_PARAM_O != 3'h0) else $error("read code wrote");
endmodule
bind stswc_cmd stswc_props i_props (.*);

/* File: verification/testbench.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
        n_errors++; \
        $display("unexpected %s: exp %h got %h", nm, e, g); \
    end
module testbench;
    localparam logic [2:0] REV = 3'h5;
    logic clk, rst_n, txd, rxd, req, pres = 1'b0, sreq, prog, stop, wr;
    logic done = 1'b0, sdone = 1'b0, sen, arm, dm, cal;
    logic [7:0] wd, rd = 8'h00, r, c;
    logic [2:0] prm, val, crd = 3'h0;
    stswc_pkg::stswc_bus_op_t op;
    stswc_pkg::stswc_speed_t spd;
    int n_errors = 0, num_checks = 0, n_req = 0, n_wr = 0, bt = 0, st = 0, slen = 20, k;
    stswc_host #(.BIT_CYC(16)) i_stswc_host (.clk_i(clk), .rxd_i(rxd), .txd_o(txd));
    stswc_cmd #(.BIT_CYC(16), .CHIP_REV(REV)) i_stswc_cmd (.REF_CLK_I(clk), .RST_N_I(rst_n),
        .TXD_I(txd), .RXD_O(rxd), .BUS_REQ_O(req), .BUS_OP_O(op), .BUS_WDATA_O(wd),
        .BUS_DONE_I(done), .BUS_RDATA_I(rd), .PRESENCE_EVT_I(pres), .SPU_REQ_O(sreq),
        .SPU_PROG_O(prog), .SPU_STOP_O(stop), .SPU_DONE_I(sdone), .CFG_WR_O(wr),
        .CFG_PARAM_O(prm), .CFG_VALUE_O(val), .CFG_RDATA_I(crd), .SPEED_O(spd),
        .SEARCH_EN_O(sen), .SPU_ARM_O(arm), .DATA_MODE_O(dm), .CAL_PENDING_O(cal));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ====================================================================
    // Bus engine and pulse timer; a zero pulse length holds until stopped
    always @(negedge clk)
    begin
        done <= bt == 1;
        sdone <= st == 1;
        bt <= req ? 6 : (bt > 0 ? bt - 1 : 0);
        st <= stop ? 0 : (sreq ? slen : (st > 0 ? st - 1 : 0));
        n_req <= n_req + int'(req);
        n_wr <= n_wr + int'(wr);
    end
    task automatic xfer(input logic [7:0] cmd, e, m);
        fork
            i_stswc_host.send(cmd, 1'b0);
            i_stswc_host.recv(r);
        join
        `CHK("answer", e & m, r & m)
    endtask
    task automatic tend(input string s);
        $display("test %s done", s);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (40000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end
    initial
    begin
        void'($urandom(32'hAAA17D80));
        rst_n = 1'b0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        i_stswc_host.send(8'hC1, 1'b0);
        `CHK("bus requests", 0, n_req)
        `CHK("calibrating", 1'b0, cal)
        tend("calibration");
        for (int s = 0; s < 4; s++)
        begin
            rd = 8'($urandom);
            xfer(8'hC1 | 8'(s << 2), {3'h6, REV, rd[1:0]}, 8'hF7);
            `CHK("speed", s == 3 ? 2'h0 : 2'(s), spd)
        end
        for (int i = 0; i < 6; i++)
        begin
            c = 8'h81 | (8'($urandom) & 8'h1E);
            rd = 8'($urandom);
            xfer(c, {c[7:2], {2{rd[0]}}}, 8'hFF);
            `CHK("slot value", c[4], wd[0])
            if (c[1])
            begin
                i_stswc_host.recv(r);
                `CHK("pullup answer", rd[0] ? 8'hEF : 8'hEC, r)
            end
        end
        crd = 3'($urandom);
        c = 8'($urandom) & 8'h0E | 8'h01;
        xfer(c, {1'b0, c[3:1], crd, 1'b0}, 8'hFF);
        c = 8'($urandom) & 8'h7E | 8'h11;
        xfer(c, {c[7:1], 1'b0}, 8'hFF);
        `CHK("config writes", 1, n_wr)
        `CHK("config target", {c[6:4], c[3:1]}, {prm, val})
        pres = 1'b1;
        @(negedge clk);
        pres = 1'b0;
        i_stswc_host.recv(r);
        `CHK("presence", 2'h1, r[1:0])
        tend("commands");
        i_stswc_host.send(8'hB5, 1'b0);
        `CHK("search flag", 1'b1, sen)
        `CHK("speed", 2'h1, spd)
        i_stswc_host.send(8'hE1, 1'b0);
        `CHK("data mode", 1'b1, dm)
        rd = 8'($urandom);
        xfer(8'($urandom) & 8'h7F, rd, 8'hFF);
        `CHK("search op", stswc_pkg::BUS_OP_SEARCH, op)
        k = n_req;
        i_stswc_host.send(8'hE3, 1'b0);
        `CHK("held byte", k, n_req)
        xfer(8'hE3, rd, 8'hFF);
        `CHK("single write", k + 1, n_req)
        `CHK("written code", 8'hE3, wd)
        i_stswc_host.send(8'hE3, 1'b0);
        i_stswc_host.send(8'hA1, 1'b0);
        `CHK("command mode", 2'h0, {dm, sen})
        tend("data mode");
        slen = 0;
        i_stswc_host.send(8'hFF, 1'b0);
        `CHK("pulse kind", 2'h3, {prog, arm})
        xfer(8'hF1, 8'hFF, 8'hFC);
        slen = 20;
        i_stswc_host.send(8'hE1, 1'b0);
        rd = 8'h80 | (8'($urandom) & 8'h1F);
        xfer(rd, rd, 8'hFF);
        `CHK("byte op", stswc_pkg::BUS_OP_BYTE, op)
        i_stswc_host.recv(r);
        `CHK("pullup end", 8'hF6, r)
        i_stswc_host.send(8'hE3, 1'b0);
        xfer(8'hED, 8'hEC, 8'hFC);
        `CHK("disarmed", 1'b0, arm)
        tend("pulses");
        i_stswc_host.send(8'h00, 1'b1);
        `CHK("master reset", 2'h1, {dm, cal})
        tend("break");
        report_and_stop();
    end
endmodule
